/* synth_latch_pkg.sv */
/*
 * shared constants and carriers for the synthesizer latch block.
 * assumes a single 40 MHz clock domain and a synchronous active-high reset.
 */
package synth_latch_pkg;
   localparam int WORD_W = 24;
   localparam int CNT_W = 5;
   localparam logic [4:0] CNT_LAST = 5'h17;
   // latch-select codes in the two low word bits
   localparam logic [1:0] SEL_CONTROL = 2'h0;
   localparam logic [1:0] SEL_REFERENCE = 2'h1;
   localparam logic [1:0] SEL_FEEDBACK = 2'h2;
   localparam logic [1:0] SEL_TEST = 2'h3;
   // control latch field positions
   localparam int CL_PRESCALER_LSB = 22;
   localparam int CL_PD_HI = 21;
   localparam int CL_PD_LO = 20;
   localparam int CL_CUR_TWO_LSB = 17;
   localparam int CL_CUR_ONE_LSB = 14;
   localparam int CL_POWER_LSB = 12;
   localparam int CL_MUTE = 11;
   localparam int CL_GAIN = 10;
   localparam int CL_FLOAT = 9;
   localparam int CL_POLARITY = 8;
   localparam int CL_MUX_LSB = 5;
   localparam int CL_CLEAR = 4;
   localparam int CL_CORE_LSB = 2;
   // feedback latch field positions
   localparam int NL_HALVED_SEL = 23;
   localparam int NL_HALVE = 22;
   localparam int NL_GAIN = 21;
   localparam int NL_MAIN_LSB = 8;
   localparam int NL_SWALLOW_LSB = 2;
   // reference latch field positions
   localparam int RL_BAND_LSB = 20;
   localparam int RL_TEST = 19;
   localparam int RL_LOCK_PREC = 18;
   localparam int RL_PULSE_LSB = 16;
   localparam int RL_DIVIDE_LSB = 2;
   localparam logic [23:0] LATCH_RESET = 24'h000000;
   // synchronous power-down waits for this many reference edges
   localparam logic [1:0] SYNC_PD_EDGES = 2'h2;
   // prescaler modulus codes
   localparam logic [1:0] PRESC_8 = 2'h0;
   localparam logic [1:0] PRESC_16 = 2'h1;
   localparam logic [1:0] PRESC_32 = 2'h2;
   // 3-wire serial port sample
   typedef struct packed {
      logic clk;
      logic data;
      logic strobe;
   } serial_t;
   // decoded control settings
   typedef struct packed {
      logic [1:0] prescaler;
      logic [2:0] current_one;
      logic [2:0] current_two;
      logic [2:0] active_current;
      logic [1:0] output_power;
      logic mute_until_lock;
      logic pump_float;
      logic detector_polarity;
      logic [2:0] monitor_sel;
      logic counter_clear;
      logic [1:0] core_current;
   } control_t;
   // decoded feedback and reference settings
   typedef struct packed {
      logic halved_feedback_select;
      logic output_halve;
      logic [12:0] main_count;
      logic [4:0] swallow_count;
      logic [13:0] ref_divide;
      logic [1:0] pulse_width;
      logic lock_precision;
      logic test_latch_enable;
      logic [1:0] band_clock_div;
   } divider_t;
   typedef enum logic [2:0] {
      PD_RUN = 3'h1,
      PD_WAIT = 3'h2,
      PD_DOWN = 3'h4
   } pd_state_t;
endpackage : synth_latch_pkg

/* edge_detect.sv */
/*
 * rising-edge detector for a synchronous input level.
 * assumes the input is already synchronous to the clock.
 */
`timescale 1ns/100ps
`default_nettype none
module edge_detect (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_level,
   output logic o_rise
);
   logic last;

   // remember the previous sample
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         last <= 1'b0;
      end else begin
         last <= i_level;
      end
   end

   assign o_rise = i_level & ~last;
endmodule : edge_detect
`default_nettype wire

/* synth_latch_control.sv */
/*
 * serial-loaded configuration latches of an integer-N synthesizer,
 * with field decode and power-down sequencing.
 * assumes serial clock, data, load strobe and reference divider output
 * are synchronous samples at 40 MHz, far slower edges than the clock.
 */
// What this block does
// R1 - 24-bit word shifted msb first, latched on strobe
// R2 - two low bits choose one of four latches
// R3 - select 00 writes the control latch
// R4 - select 10 writes the feedback counter latch
// R5 - select 01 writes the reference counter latch
// R6 - host writes reference, control, then feedback
// R7 - top control bits pick prescaler modulus
// R8 - power-down bits pick normal, async, sync
// R9 - async power-down takes effect immediately
// R10 - sync power-down on second reference edge
// R11 - power-down clears counters, floats pump, resets lock
// R12 - serial port keeps working while powered down
// R13 - two 3-bit pump current codes, eight steps
// R14 - 2-bit field selects output power level
// R15 - mute output until digital lock
// R16 - gain bit selects current setting two
// R17 - float bit three-states the charge pump
// R18 - polarity bit sets detector sense
// R19 - other latches unchanged by a load
`timescale 1ns/100ps
`default_nettype none
module synth_latch_control (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_SERIAL_CLK,
   input wire logic I_SERIAL_DATA,
   input wire logic I_LOAD_STROBE,
   input wire logic I_REF_DIV_OUT,
   input wire logic I_LOCK_DETECT,
   output logic [1:0] O_PRESCALER,
   output logic [2:0] O_PUMP_CURRENT,
   output logic [1:0] O_OUTPUT_POWER,
   output logic O_RF_ENABLE,
   output logic O_PUMP_FLOAT,
   output logic O_DETECTOR_POLARITY,
   output logic [2:0] O_MONITOR_SEL,
   output logic [1:0] O_CORE_CURRENT,
   output logic O_COUNTER_LOAD,
   output logic O_LOCK_RESET,
   output logic O_REF_BUFFER_ENABLE,
   output logic O_POWERED_DOWN,
   output logic [12:0] O_MAIN_COUNT,
   output logic [4:0] O_SWALLOW_COUNT,
   output logic [13:0] O_REF_DIVIDE,
   output logic O_OUTPUT_HALVE,
   output logic O_HALVED_FEEDBACK_SELECT,
   output logic [1:0] O_PULSE_WIDTH,
   output logic O_LOCK_PRECISION,
   output logic O_TEST_LATCH_ENABLE,
   output logic [1:0] O_BAND_CLOCK_DIV,
   output logic O_FEEDBACK_UPDATED
);
   synth_latch_pkg::serial_t port;
   logic [23:0] shift;
   logic [23:0] main_control_latch;
   logic [23:0] feedback_counter_latch;
   logic [23:0] reference_counter_latch;
   logic [23:0] test_latch;
   logic gain_select;
   logic clk_rise;
   logic strobe_rise;
   logic ref_rise;
   logic [1:0] ref_edges;
   synth_latch_pkg::pd_state_t pd_state;
   synth_latch_pkg::pd_state_t next_pd_state;
   synth_latch_pkg::control_t ctl;
   synth_latch_pkg::divider_t div;

   assign port.clk = I_SERIAL_CLK;
   assign port.data = I_SERIAL_DATA;
   assign port.strobe = I_LOAD_STROBE;

   // edge finders for serial clock, strobe and reference output
   edge_detect u_clk_edge (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_level(port.clk),
      .o_rise(clk_rise)
   );
   edge_detect u_strobe_edge (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_level(port.strobe),
      .o_rise(strobe_rise)
   );
   edge_detect u_ref_edge (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_level(I_REF_DIV_OUT),
      .o_rise(ref_rise)
   );

   // latch-select decode from the shifted word
   wire [1:0] select = shift[1:0]; // [R2]
   wire load_control = strobe_rise &
      (select == synth_latch_pkg::SEL_CONTROL); // [R3]
   wire load_feedback = strobe_rise &
      (select == synth_latch_pkg::SEL_FEEDBACK); // [R4]
   wire load_reference = strobe_rise &
      (select == synth_latch_pkg::SEL_REFERENCE); // [R5]
   wire load_test = strobe_rise &
      (select == synth_latch_pkg::SEL_TEST); // [R2]

   // power-down request decoded from the incoming control word
   wire pd_lo_new = shift[synth_latch_pkg::CL_PD_LO];
   wire pd_hi_new = shift[synth_latch_pkg::CL_PD_HI];
   wire async_req = load_control & pd_lo_new & ~pd_hi_new; // [R9]
   wire sync_req = load_control & pd_lo_new & pd_hi_new; // [R10]
   wire wake_req = load_control & ~pd_lo_new; // [R8]

   // shift register, msb first; never gated by power-down
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         shift <= synth_latch_pkg::LATCH_RESET;
      end else if (clk_rise) begin
         shift <= {shift[22:0], port.data}; // [R1] [R12]
      end
   end

   // each latch updates only on its own select; others hold
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         main_control_latch <= synth_latch_pkg::LATCH_RESET;
         feedback_counter_latch <= synth_latch_pkg::LATCH_RESET;
         reference_counter_latch <= synth_latch_pkg::LATCH_RESET;
         test_latch <= synth_latch_pkg::LATCH_RESET;
      end else begin
         if (load_control) begin
            main_control_latch <= shift; // [R3] [R19]
         end
         if (load_feedback) begin
            feedback_counter_latch <= shift; // [R4] [R19]
         end
         if (load_reference) begin
            reference_counter_latch <= shift; // [R5] [R19]
         end
         if (load_test) begin
            test_latch <= shift; // [R2]
         end
      end
   end

   // gain bit shared by two latches: latest write wins
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         gain_select <= 1'b0;
      end else if (load_control) begin
         gain_select <= shift[synth_latch_pkg::CL_GAIN]; // [R16]
      end else if (load_feedback) begin
         gain_select <= shift[synth_latch_pkg::NL_GAIN]; // [R16]
      end
   end

   // power-down sequencing: async immediate, sync after two ref edges
   always_comb begin
      next_pd_state = pd_state;
      case (pd_state)
         synth_latch_pkg::PD_RUN: begin
            if (async_req) begin
               next_pd_state = synth_latch_pkg::PD_DOWN; // [R9]
            end else if (sync_req) begin
               next_pd_state = synth_latch_pkg::PD_WAIT; // [R10]
            end
         end
         synth_latch_pkg::PD_WAIT: begin
            if (wake_req) begin
               next_pd_state = synth_latch_pkg::PD_RUN; // [R8]
            end else if (async_req) begin
               next_pd_state = synth_latch_pkg::PD_DOWN; // [R9]
            end else if (ref_rise &&
               ref_edges == synth_latch_pkg::SYNC_PD_EDGES - 2'h1) begin
               next_pd_state = synth_latch_pkg::PD_DOWN; // [R10]
            end
         end
         synth_latch_pkg::PD_DOWN: begin
            if (wake_req) begin
               next_pd_state = synth_latch_pkg::PD_RUN; // [R8]
            end
         end
         default: begin
            next_pd_state = synth_latch_pkg::PD_RUN;
         end
      endcase
   end

   // state register and reference edge count since the strobe
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         pd_state <= synth_latch_pkg::PD_RUN;
         ref_edges <= 2'h0;
      end else begin
         pd_state <= next_pd_state;
         if (sync_req) begin
            ref_edges <= 2'h0; // [R10]
         end else if (pd_state == synth_latch_pkg::PD_WAIT && ref_rise) begin
            ref_edges <= 2'(ref_edges + 2'h1);
         end
      end
   end

   wire down = (pd_state == synth_latch_pkg::PD_DOWN);

   // control field decode, straight from the stored latch
   wire [1:0] presc_code =
      main_control_latch[synth_latch_pkg::CL_PRESCALER_LSB +: 2]; // [R7]
   assign ctl.prescaler =
      (presc_code == synth_latch_pkg::PRESC_8) ?
      synth_latch_pkg::PRESC_8 :
      (presc_code == synth_latch_pkg::PRESC_16) ?
      synth_latch_pkg::PRESC_16 : synth_latch_pkg::PRESC_32; // [R7]
   assign ctl.current_one =
      main_control_latch[synth_latch_pkg::CL_CUR_ONE_LSB +: 3]; // [R13]
   assign ctl.current_two =
      main_control_latch[synth_latch_pkg::CL_CUR_TWO_LSB +: 3]; // [R13]
   assign ctl.active_current = gain_select ?
      ctl.current_two : ctl.current_one; // [R16]
   assign ctl.output_power =
      main_control_latch[synth_latch_pkg::CL_POWER_LSB +: 2]; // [R14]
   assign ctl.mute_until_lock =
      main_control_latch[synth_latch_pkg::CL_MUTE]; // [R15]
   assign ctl.pump_float =
      main_control_latch[synth_latch_pkg::CL_FLOAT]; // [R17]
   assign ctl.detector_polarity =
      main_control_latch[synth_latch_pkg::CL_POLARITY]; // [R18]
   assign ctl.monitor_sel =
      main_control_latch[synth_latch_pkg::CL_MUX_LSB +: 3];
   assign ctl.counter_clear = main_control_latch[synth_latch_pkg::CL_CLEAR];
   assign ctl.core_current =
      main_control_latch[synth_latch_pkg::CL_CORE_LSB +: 2];

   // feedback and reference field decode
   assign div.halved_feedback_select =
      feedback_counter_latch[synth_latch_pkg::NL_HALVED_SEL]; // [R4]
   assign div.output_halve =
      feedback_counter_latch[synth_latch_pkg::NL_HALVE]; // [R4]
   assign div.main_count =
      feedback_counter_latch[synth_latch_pkg::NL_MAIN_LSB +: 13]; // [R4]
   assign div.swallow_count =
      feedback_counter_latch[synth_latch_pkg::NL_SWALLOW_LSB +: 5]; // [R4]
   assign div.ref_divide =
      reference_counter_latch[synth_latch_pkg::RL_DIVIDE_LSB +: 14]; // [R5]
   assign div.pulse_width =
      reference_counter_latch[synth_latch_pkg::RL_PULSE_LSB +: 2]; // [R5]
   assign div.lock_precision =
      reference_counter_latch[synth_latch_pkg::RL_LOCK_PREC]; // [R5]
   assign div.test_latch_enable =
      reference_counter_latch[synth_latch_pkg::RL_TEST]; // [R5]
   assign div.band_clock_div =
      reference_counter_latch[synth_latch_pkg::RL_BAND_LSB +: 2]; // [R5]

   // registered outputs; power-down overrides pump, counters, lock
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_PRESCALER <= 2'h0;
         O_PUMP_CURRENT <= 3'h0;
         O_OUTPUT_POWER <= 2'h0;
         O_RF_ENABLE <= 1'b0;
         O_PUMP_FLOAT <= 1'b1;
         O_DETECTOR_POLARITY <= 1'b0;
         O_MONITOR_SEL <= 3'h0;
         O_CORE_CURRENT <= 2'h0;
         O_COUNTER_LOAD <= 1'b1;
         O_LOCK_RESET <= 1'b1;
         O_REF_BUFFER_ENABLE <= 1'b0;
         O_POWERED_DOWN <= 1'b0;
         O_FEEDBACK_UPDATED <= 1'b0;
      end else begin
         O_PRESCALER <= ctl.prescaler; // [R7]
         O_PUMP_CURRENT <= ctl.active_current; // [R13] [R16]
         O_OUTPUT_POWER <= ctl.output_power; // [R14]
         O_RF_ENABLE <= ~down &
            (~ctl.mute_until_lock | I_LOCK_DETECT); // [R15]
         O_PUMP_FLOAT <= ctl.pump_float | down; // [R17] [R11]
         O_DETECTOR_POLARITY <= ctl.detector_polarity; // [R18]
         O_MONITOR_SEL <= ctl.monitor_sel;
         O_CORE_CURRENT <= ctl.core_current;
         O_COUNTER_LOAD <= ctl.counter_clear | down; // [R11]
         O_LOCK_RESET <= down; // [R11]
         O_REF_BUFFER_ENABLE <= ~down; // [R11]
         O_POWERED_DOWN <= down; // [R9] [R10]
         O_FEEDBACK_UPDATED <= load_feedback;
      end
   end

   // counter settings pass through a register stage
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_MAIN_COUNT <= 13'h0000;
         O_SWALLOW_COUNT <= 5'h00;
         O_REF_DIVIDE <= 14'h0000;
         O_OUTPUT_HALVE <= 1'b0;
         O_HALVED_FEEDBACK_SELECT <= 1'b0;
         O_PULSE_WIDTH <= 2'h0;
         O_LOCK_PRECISION <= 1'b0;
         O_TEST_LATCH_ENABLE <= 1'b0;
         O_BAND_CLOCK_DIV <= 2'h0;
      end else begin
         O_MAIN_COUNT <= div.main_count;
         O_SWALLOW_COUNT <= div.swallow_count;
         O_REF_DIVIDE <= div.ref_divide;
         O_OUTPUT_HALVE <= div.output_halve;
         O_HALVED_FEEDBACK_SELECT <= div.halved_feedback_select;
         O_PULSE_WIDTH <= div.pulse_width;
         O_LOCK_PRECISION <= div.lock_precision;
         O_TEST_LATCH_ENABLE <= div.test_latch_enable;
         O_BAND_CLOCK_DIV <= div.band_clock_div;
      end
   end
endmodule : synth_latch_control
`default_nettype wire

/* synth_host_model.sv */
/* host model for the 3-wire serial port of the latch block.
   assumes a free-running clock; serial clock idles low between words. */
`timescale 1ns/100ps
`default_nettype none
module synth_host_model (
   input wire logic i_clk,
   output var synth_latch_pkg::serial_t o_serial
);
   // every level is held at least two clocks so the sampler never misses one
   task automatic hold(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask : hold
   // one word msb first, strobe raised after the last rise
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         o_serial.data = w[i];
         o_serial.clk = 1'h0;
         hold(2);
         o_serial.clk = 1'h1;
         hold(2);
      end
      o_serial.clk = 1'h0;
      o_serial.data = ~w[0]; // released line shows no stale bit
      hold(2);
      o_serial.strobe = 1'h1;
      hold(3);
      o_serial.strobe = 1'h0;
      hold(2);
   endtask : send
   initial begin
      o_serial = '0;
   end
endmodule : synth_host_model
`default_nettype wire

/* synth_latch_checker.sv */
/* pin-level checks of the latch block.
   assumes one clock, synchronous active-high reset; bound at the foot. */
`timescale 1ns/100ps
`default_nettype none
module synth_latch_checker (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_LOAD_STROBE,
   input wire logic I_REF_DIV_OUT,
   input wire logic [1:0] O_PRESCALER,
   input wire logic O_RF_ENABLE,
   input wire logic O_PUMP_FLOAT,
   input wire logic O_COUNTER_LOAD,
   input wire logic O_LOCK_RESET,
   input wire logic O_REF_BUFFER_ENABLE,
   input wire logic O_POWERED_DOWN,
   input wire logic [12:0] O_MAIN_COUNT,
   input wire logic [13:0] O_REF_DIVIDE,
   input wire logic O_FEEDBACK_UPDATED
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   // strobe rise two edges back: latch then output register
   sequence s_loaded;
      $past(I_LOAD_STROBE, 2) && !$past(I_LOAD_STROBE, 3);
   endsequence
   // strobe rise one edge back: pulse comes straight from the decode
   sequence s_strobed;
      $past(I_LOAD_STROBE) && !$past(I_LOAD_STROBE, 2);
   endsequence
   // a load or a reference rise, the two causes of power-down
   sequence s_cause;
      ($past(I_LOAD_STROBE, 2) && !$past(I_LOAD_STROBE, 3)) ||
      ($past(I_REF_DIV_OUT, 2) && !$past(I_REF_DIV_OUT, 3));
   endsequence
   a_field_needs_load:
      assert property ($changed(O_REF_DIVIDE) || $changed(O_MAIN_COUNT)
         |-> s_loaded) else $error("field changed without a load");
   a_prescaler_code:
      assert property (O_PRESCALER != 2'h3)
      else $error("prescaler code 3 driven");
   a_down_outputs:
      assert property (O_POWERED_DOWN |-> O_PUMP_FLOAT && O_LOCK_RESET
         && O_COUNTER_LOAD) else $error("power-down outputs wrong");
   a_down_rf_off:
      assert property (O_POWERED_DOWN |-> !O_RF_ENABLE)
      else $error("rf enabled while down");
   a_down_has_cause:
      assert property ($rose(O_POWERED_DOWN) |-> s_cause)
      else $error("power-down without cause");
   a_wake_on_load:
      assert property ($fell(O_POWERED_DOWN) |-> s_loaded)
      else $error("wake without a load");
   a_update_pulse:
      assert property (O_FEEDBACK_UPDATED |-> s_strobed
         ##1 !O_FEEDBACK_UPDATED) else $error("feedback pulse wrong");
   a_buffer_tracks:
      assert property (!$past(I_RESET) |->
         O_REF_BUFFER_ENABLE == !O_POWERED_DOWN)
      else $error("reference buffer wrong");
endmodule : synth_latch_checker
bind synth_latch_control synth_latch_checker i_synth_latch_checker (.*);
`default_nettype wire

/* synth_latch_control_bench.sv */
/* self-checking bench for the latch block with the host model.
   assumes the checker is bound; stimulus lands 2 ns after each edge. */
`timescale 1ns/100ps
`default_nettype none
module synth_latch_control_bench;
   logic I_CLK, I_RESET, I_REF_DIV_OUT, I_LOCK_DETECT;
   synth_latch_pkg::serial_t ser;
   wire logic I_SERIAL_CLK = ser.clk;
   wire logic I_SERIAL_DATA = ser.data;
   wire logic I_LOAD_STROBE = ser.strobe;
   wire logic [1:0] O_PRESCALER, O_OUTPUT_POWER, O_CORE_CURRENT;
   wire logic [1:0] O_PULSE_WIDTH, O_BAND_CLOCK_DIV;
   wire logic [2:0] O_PUMP_CURRENT, O_MONITOR_SEL;
   wire logic O_RF_ENABLE, O_PUMP_FLOAT, O_DETECTOR_POLARITY;
   wire logic O_COUNTER_LOAD, O_LOCK_RESET, O_REF_BUFFER_ENABLE;
   wire logic O_POWERED_DOWN, O_OUTPUT_HALVE, O_HALVED_FEEDBACK_SELECT;
   wire logic O_LOCK_PRECISION, O_TEST_LATCH_ENABLE, O_FEEDBACK_UPDATED;
   wire logic [12:0] O_MAIN_COUNT;
   wire logic [4:0] O_SWALLOW_COUNT;
   wire logic [13:0] O_REF_DIVIDE;
   int mismatches = 0;
   int checks_done = 0;
   // band, test, precision, pulse, divide
   localparam logic [19:0] REF_EXP = {2'h2, 1'h1, 1'h1, 2'h1, 14'h1ABC};
   // halved select, halve, main, swallow
   localparam logic [19:0] FB_EXP = {1'h1, 1'h0, 13'h0F0F, 5'h15};
   // float, counter load, lock reset, ref buffer, rf, down
   localparam logic [5:0] RUN_EXP = 6'h06;
   localparam logic [5:0] DOWN_EXP = 6'h39;
   // grouped pins keep the compare count low
   wire logic [5:0] pd_grp = {O_PUMP_FLOAT, O_COUNTER_LOAD, O_LOCK_RESET,
      O_REF_BUFFER_ENABLE, O_RF_ENABLE, O_POWERED_DOWN};
   wire logic [19:0] ref_grp = {O_BAND_CLOCK_DIV, O_TEST_LATCH_ENABLE,
      O_LOCK_PRECISION, O_PULSE_WIDTH, O_REF_DIVIDE};
   wire logic [19:0] fb_grp = {O_HALVED_FEEDBACK_SELECT, O_OUTPUT_HALVE,
      O_MAIN_COUNT, O_SWALLOW_COUNT};
   synth_latch_control i_synth_latch_control (.*);
   synth_host_model i_synth_host_model (.i_clk(I_CLK), .o_serial(ser));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic hold(input int n);
      repeat (n) @(posedge I_CLK);
      #2;
   endtask : hold
   task automatic check(input string what, input logic [23:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic put(input logic [23:0] w);
      i_synth_host_model.send(w);
   endtask : put
   // reference divider pulse, two clocks high and low
   task automatic ref_pulse;
      I_REF_DIV_OUT = 1'h1;
      hold(2);
      I_REF_DIV_OUT = 1'h0;
      hold(2);
   endtask : ref_pulse
   // control word from prescaler, power-down, currents, power, flags
   function automatic logic [23:0] ctl(logic [1:0] p, pd,
         logic [5:0] cur, logic [1:0] pw, logic [3:0] f);
      return {p, pd, cur, pw, f, 6'h00, 2'h0};
   endfunction : ctl
   initial begin
      I_CLK = 1'h0;
      forever #12.5 I_CLK = ~I_CLK;
   end
   // the run needs some 1260 clocks; this gives ample margin
   initial begin
      repeat (6000) @(posedge I_CLK);
      $display("watchdog expired");
      mismatches++;
      complete_run();
   end
   initial begin
      I_RESET = 1'h1;
      I_REF_DIV_OUT = 1'h0;
      I_LOCK_DETECT = 1'h0;
      hold(8);
      I_RESET = 1'h0;
      hold(2);
      check("idle pins", pd_grp, RUN_EXP);
      // reference, then control, then feedback
      put({2'h0, REF_EXP, 2'h1});
      check("ref fields", ref_grp, REF_EXP);
      $display("test reference done");
      put(24'h0008B8); // mute, mux 5, clear, core 2
      check("mux core", {O_MONITOR_SEL, O_CORE_CURRENT}, 5'h16);
      check("clear", O_COUNTER_LOAD, 1'h1);
      check("muted", O_RF_ENABLE, 1'h0);
      I_LOCK_DETECT = 1'h1;
      hold(3);
      check("locked", O_RF_ENABLE, 1'h1);
      for (int i = 0; i < 4; i++) begin
         put(ctl(i[1:0], 2'h0, 6'h15, i[1:0], {1'h0, i[0], i[1], ~i[0]}));
         check("prescaler", O_PRESCALER, (i == 3) ? 2'h2 : i[1:0]);
         check("power", O_OUTPUT_POWER, i[1:0]);
         check("current", O_PUMP_CURRENT, i[0] ? 3'h2 : 3'h5);
         check("float", O_PUMP_FLOAT, i[1]);
         check("polarity", O_DETECTOR_POLARITY, !i[0]);
         check("ref kept", ref_grp, REF_EXP);
      end
      $display("test control done");
      put({FB_EXP[19:18], 1'h0, FB_EXP[17:5], 1'h0, FB_EXP[4:0], 2'h2});
      check("fb fields", fb_grp, FB_EXP);
      check("fb gain", O_PUMP_CURRENT, 3'h5);
      check("presc kept", O_PRESCALER, 2'h2);
      put(24'hFFFFFF); // test latch select touches no pin
      check("test sel", {fb_grp, O_PRESCALER}, {FB_EXP, 2'h2});
      check("test ref", ref_grp, REF_EXP);
      $display("test feedback done");
      put(ctl(2'h0, 2'h1, 6'h00, 2'h0, 4'h0));
      check("async down", pd_grp, DOWN_EXP);
      put(24'h000005);
      check("live port", ref_grp, 20'h00001);
      put(ctl(2'h0, 2'h2, 6'h00, 2'h0, 4'h0));
      check("wake", pd_grp, RUN_EXP);
      put(ctl(2'h0, 2'h3, 6'h00, 2'h0, 4'h0));
      check("sync wait", O_POWERED_DOWN, 1'h0);
      ref_pulse();
      check("one edge", O_POWERED_DOWN, 1'h0);
      ref_pulse();
      check("sync down", pd_grp, DOWN_EXP);
      $display("test power-down done");
      complete_run();
   end
endmodule : synth_latch_control_bench
`default_nettype wire
